// file: inc/amst_pkg.sv
// constants shared by the analog module scan controller
package amst_pkg;
    localparam int CLK_NS   = 4;
    localparam int STEP_NS  = 40;
    localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int NUM_IN   = 8;
    localparam int NUM_OUT  = 4;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SET  = 8'h04;
    localparam logic [7:0] OFF_PTR  = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0c;
    localparam logic [7:0] OFF_CFGA = 8'h10;
    localparam logic [7:0] OFF_CFGB = 8'h14;
    localparam logic [7:0] OFF_CFGC = 8'h18;
    localparam logic [7:0] OFF_LAST = 8'h1c;
    localparam logic [2:0] OFF_IN_REGION  = 3'h1;
    localparam logic [3:0] OFF_OUT_REGION = 4'h4;

    localparam int CTRL_RUN    = 0;
    localparam int CTRL_REMOTE = 1;
    localparam int CTRL_INCNT  = 4;
    localparam int CTRL_OUTCNT = 8;
    localparam int CTRL_SLOT   = 12;
    localparam int STAT_BUSY   = 0;
    localparam int STAT_REMOTE = 1;
    localparam int STAT_MISM   = 2;
    localparam int STAT_ROT    = 3;
    localparam int STAT_SCANS  = 16;

    localparam int HS_INCH  = 16;
    localparam int HS_OUTCH = 19;
    localparam int HS_STB   = 21;
    localparam int HS_SET   = 22;
    localparam int HS_TOP   = 26;
    localparam int X_ID     = 16;

    localparam logic [3:0] IN_CNT_MAX  = 4'h8;
    localparam logic [2:0] OUT_CNT_MAX = 3'h4;

    localparam logic [15:0] LOC_FMT  = 16'h0fb0;
    localparam logic [15:0] LOC_INP  = 16'h0fb8;
    localparam logic [15:0] LOC_OUTP = 16'h0fc0;
    localparam logic [15:0] LOC_RES  = 16'h3d00;
    localparam logic [15:0] LOC_TH   = 16'h3d10;
    localparam logic [15:0] EXP_FMT  = 16'h3c00;
    localparam logic [15:0] EXP_INP  = 16'h3c08;
    localparam logic [15:0] EXP_OUTP = 16'h3c10;
    localparam logic [15:0] EXP_RES  = 16'h3c18;
    localparam logic [15:0] EXP_TH   = 16'h3c28;
    localparam logic [15:0] PTR_GAP  = 16'h0008;
endpackage

// file: logic/amst_store.sv
// per-channel store of the input values taken during the scans
module amst_store #(
    parameter int DEPTH = 8,
    parameter int W     = 16
) (
    input  wire logic                     clk,
    input  wire logic                     rstn,
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] widx,
    input  wire logic [W-1:0]             wdata,
    input  wire logic [$clog2(DEPTH)-1:0] ridx,
    output logic      [W-1:0]             rdata
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
    } amst_store_t;

    amst_store_t q;
    amst_store_t n;

    always_comb begin
        n = q;
        if (we) begin
            n.mem[widx] = wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign rdata = q.mem[ridx];
endmodule

// file: logic/amst_rotor.sv
// channel rotation index for one-channel-per-scan bases
module amst_rotor #(
    parameter int N = 8
) (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 clr,
    input  wire logic                 step,
    input  wire logic [3:0]           limit,
    output logic      [$clog2(N)-1:0] idx
);
    typedef struct packed {
        logic [$clog2(N)-1:0] idx;
    } amst_rotor_t;

    amst_rotor_t q;
    amst_rotor_t n;

    always_comb begin
        n = q;
        if (clr) begin
            n.idx = '0;
        end else if (step) begin
            // wrap at the enabled channel count, not at N
            if (4'(q.idx) + 4'h1 >= limit) begin
                n.idx = '0;
            end else begin
                n.idx = q.idx + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign idx = q.idx;
endmodule

// file: logic/amst_host.sv
// scan controller driving the analog module's discrete points, with apb registers
// Operation
// - local base: all enabled input channels are moved in one scan
// - expansion or remote base: one input channel is moved per scan
// - one-per-scan: successive scans step through channels in order, then wrap
// - local base: all enabled output channels are refreshed every scan when at least as many input channels are enabled
// - expansion or remote base: at most one output channel refreshed per scan
// - expansion or remote base: output refresh follows the input rotation, each output every eight scans when eight input channels are enabled
// - first output word carries the 16-bit straight binary output value
// - second output word is kept for handshaking, never user data
// - controller keeps per-slot counts, pointers, resolution, range, track-hold
// - per-slot configuration is taken only at a mode transition
// - slots count from 0 beside the base controller up to 7
// - cpu base: format, input and output pointer words at base plus slot
// - expansion base one: same three words at its bases plus slot
// - cpu base: resolution and track-hold words at their bases plus slot
module amst_host #(
    parameter int SCAN_GAP_CYC = 64
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] x_in,
    output logic      [31:0] y_out
);
    typedef enum logic [2:0] {S_IDLE, S_DRIVE, S_WAIT, S_SAMPLE, S_DONE} amst_phase_t;

    typedef struct packed {
        amst_phase_t             phase;
        logic                    run;
        logic                    run_d;
        logic                    remote;
        logic [3:0]              in_cnt;
        logic [2:0]              out_cnt;
        logic [2:0]              slot;
        logic [3:0]              set;
        logic [15:0]             in_ptr;
        logic [15:0]             out_ptr;
        logic                    a_remote;
        logic [3:0]              a_in_cnt;
        logic [2:0]              a_out_cnt;
        logic [2:0]              a_slot;
        logic [3:0]              a_set;
        logic [15:0]             a_in_ptr;
        logic [3:0][15:0]        out_val;
        logic [15:0]             timer;
        logic [2:0]              k;
        logic [3:0]              steps;
        logic [2:0]              outs;
        logic [15:0]             scan_cnt;
        logic                    mism;
        logic [15:0]             last_addr;
        logic                    st_we;
        logic [2:0]              st_idx;
        logic [15:0]             st_data;
        logic                    rot_step;
        logic                    rot_clr;
        logic [31:0]             y_out;
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
    } amst_host_t;

    amst_host_t  q;
    amst_host_t  n;
    logic [2:0]  rot_idx;
    logic [15:0] st_rdata;
    logic        apb_go;
    logic        apb_fin;
    logic        in_reg;
    logic        out_reg;
    logic        hit;
    logic        hit_w;
    logic        stb;
    logic [31:0] rd_data;
    logic [15:0] fmt_addr;
    logic [15:0] inp_addr;
    logic [15:0] outp_addr;
    logic [15:0] res_addr;
    logic [15:0] th_addr;

    amst_store #(
        .DEPTH (amst_pkg::NUM_IN),
        .W     (16)
    ) u_store (
        .clk   (clk),
        .rstn  (rstn),
        .we    (q.st_we),
        .widx  (q.st_idx),
        .wdata (q.st_data),
        .ridx  (paddr[4:2]),
        .rdata (st_rdata)
    );

    amst_rotor #(
        .N (amst_pkg::NUM_IN)
    ) u_rotor (
        .clk   (clk),
        .rstn  (rstn),
        .clr   (q.rot_clr),
        .step  (q.rot_step),
        .limit (q.a_in_cnt),
        .idx   (rot_idx)
    );

    // one wait state: data is prepared on the first access cycle
    assign apb_go  = psel & penable & ~q.pready;
    assign apb_fin = psel & penable & q.pready;
    assign in_reg  = paddr[7:5] == amst_pkg::OFF_IN_REGION;
    assign out_reg = paddr[7:4] == amst_pkg::OFF_OUT_REGION;
    assign stb     = q.k < q.a_out_cnt;

    // slot-dependent configuration locations; slot 0 sits beside the base controller
    always_comb begin
        if (q.a_remote) begin
            fmt_addr  = amst_pkg::EXP_FMT + 16'(q.a_slot);
            inp_addr  = amst_pkg::EXP_INP + 16'(q.a_slot);
            outp_addr = amst_pkg::EXP_OUTP + 16'(q.a_slot);
            res_addr  = amst_pkg::EXP_RES + 16'(q.a_slot);
            th_addr   = amst_pkg::EXP_TH + 16'(q.a_slot);
        end else begin
            fmt_addr  = amst_pkg::LOC_FMT + 16'(q.a_slot);
            inp_addr  = amst_pkg::LOC_INP + 16'(q.a_slot);
            outp_addr = amst_pkg::LOC_OUTP + 16'(q.a_slot);
            res_addr  = amst_pkg::LOC_RES + 16'(q.a_slot);
            th_addr   = amst_pkg::LOC_TH + 16'(q.a_slot);
        end
    end

    always_comb begin
        rd_data = '0;
        hit     = 1'b1;
        hit_w   = 1'b0;
        case (paddr)
            amst_pkg::OFF_CTRL: begin
                hit_w                                   = 1'b1;
                rd_data[amst_pkg::CTRL_RUN]             = q.run;
                rd_data[amst_pkg::CTRL_REMOTE]          = q.remote;
                rd_data[amst_pkg::CTRL_INCNT +: 4]      = q.in_cnt;
                rd_data[amst_pkg::CTRL_OUTCNT +: 3]     = q.out_cnt;
                rd_data[amst_pkg::CTRL_SLOT +: 3]       = q.slot;
            end
            amst_pkg::OFF_SET: begin
                hit_w        = 1'b1;
                rd_data[3:0] = q.set;
            end
            amst_pkg::OFF_PTR: begin
                hit_w   = 1'b1;
                rd_data = {q.out_ptr, q.in_ptr};
            end
            amst_pkg::OFF_STAT: begin
                hit_w                                = 1'b1;
                rd_data[amst_pkg::STAT_BUSY]         = q.phase != S_IDLE;
                rd_data[amst_pkg::STAT_REMOTE]       = q.a_remote;
                rd_data[amst_pkg::STAT_MISM]         = q.mism;
                rd_data[amst_pkg::STAT_ROT +: 3]     = rot_idx;
                rd_data[amst_pkg::STAT_SCANS +: 16]  = q.scan_cnt;
            end
            amst_pkg::OFF_CFGA: rd_data = {inp_addr, fmt_addr};
            amst_pkg::OFF_CFGB: rd_data = {res_addr, outp_addr};
            amst_pkg::OFF_CFGC: rd_data = {16'h0000, th_addr};
            amst_pkg::OFF_LAST: rd_data = {16'h0000, q.last_addr};
            default: begin
                if (in_reg) begin
                    rd_data[15:0] = st_rdata;
                end else if (out_reg) begin
                    hit_w         = 1'b1;
                    rd_data[15:0] = q.out_val[paddr[3:2]];
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
    end

    always_comb begin
        n          = q;
        n.st_we    = 1'b0;
        n.rot_step = 1'b0;
        n.rot_clr  = 1'b0;
        n.run_d    = q.run;
        n.pready   = apb_go;
        n.pslverr  = apb_go & ~hit;
        if (apb_go) begin
            n.prdata = rd_data;
        end
        // writes land on the completing edge only
        if (apb_fin && pwrite && hit_w) begin
            case (paddr)
                amst_pkg::OFF_CTRL: begin
                    n.run     = pwdata[amst_pkg::CTRL_RUN];
                    n.remote  = pwdata[amst_pkg::CTRL_REMOTE];
                    n.in_cnt  = pwdata[amst_pkg::CTRL_INCNT +: 4];
                    n.out_cnt = pwdata[amst_pkg::CTRL_OUTCNT +: 3];
                    n.slot    = pwdata[amst_pkg::CTRL_SLOT +: 3];
                end
                amst_pkg::OFF_SET: n.set = pwdata[3:0];
                amst_pkg::OFF_PTR: begin
                    n.in_ptr  = pwdata[15:0];
                    n.out_ptr = pwdata[31:16];
                end
                amst_pkg::OFF_STAT: begin
                    if (pwdata[amst_pkg::STAT_MISM]) begin
                        n.mism = 1'b0;
                    end
                end
                default: n.out_val[paddr[3:2]] = pwdata[15:0];
            endcase
        end
        // shadow settings only reach the scan when run rises
        if (q.run && !q.run_d) begin
            n.a_remote  = q.remote;
            n.a_in_cnt  = (q.in_cnt == 4'h0 || q.in_cnt > amst_pkg::IN_CNT_MAX) ?
                          amst_pkg::IN_CNT_MAX : q.in_cnt;
            n.a_out_cnt = (q.out_cnt > amst_pkg::OUT_CNT_MAX) ?
                          amst_pkg::OUT_CNT_MAX : q.out_cnt;
            n.a_slot    = q.slot;
            n.a_set     = q.set;
            n.a_in_ptr  = q.in_ptr;
            n.rot_clr   = 1'b1;
            n.timer     = '0;
        end
        case (q.phase)
            S_IDLE: begin
                if (q.run && q.run_d) begin
                    if (q.timer != 16'h0000) begin
                        n.timer = q.timer - 16'h0001;
                    end else begin
                        // rotor clear lands one edge late, so ignore a stale index
                        n.k     = (q.a_remote && !q.rot_clr) ? rot_idx : 3'h0;
                        n.steps = '0;
                        n.outs  = '0;
                        n.phase = S_DRIVE;
                    end
                end
            end
            S_DRIVE: begin
                n.y_out                          = {16'h0000, q.out_val[q.k[1:0]]};
                n.y_out[amst_pkg::HS_INCH +: 3]  = q.k;
                n.y_out[amst_pkg::HS_OUTCH +: 2] = q.k[1:0];
                n.y_out[amst_pkg::HS_STB]        = stb;
                n.y_out[amst_pkg::HS_SET +: 4]   = q.a_set;
                n.timer                          = 16'(amst_pkg::STEP_CYC - 1);
                n.phase                          = S_WAIT;
            end
            S_WAIT: begin
                if (q.timer != 16'h0000) begin
                    n.timer = q.timer - 16'h0001;
                end else begin
                    n.phase = S_SAMPLE;
                end
            end
            S_SAMPLE: begin
                n.st_we   = 1'b1;
                n.st_idx  = q.k;
                n.st_data = x_in[15:0];
                // set wins over a clear in the same cycle
                if (x_in[amst_pkg::X_ID +: 3] != q.k) begin
                    n.mism = 1'b1;
                end
                n.last_addr               = q.a_in_ptr + 16'(q.k);
                n.steps                   = q.steps + 4'h1;
                n.outs                    = q.outs + 3'(stb);
                n.y_out[amst_pkg::HS_STB] = 1'b0;
                if (q.a_remote || 4'(q.k) + 4'h1 >= q.a_in_cnt) begin
                    n.rot_step = q.a_remote;
                    n.phase    = S_DONE;
                end else begin
                    n.k     = q.k + 3'h1;
                    n.phase = S_DRIVE;
                end
            end
            S_DONE: begin
                n.scan_cnt = q.scan_cnt + 16'h0001;
                n.timer    = 16'(SCAN_GAP_CYC);
                n.phase    = S_IDLE;
            end
            default: n.phase = S_IDLE;
        endcase
        // stopping abandons a scan; restart takes fresh settings
        if (!q.run) begin
            n.phase                   = S_IDLE;
            n.y_out[amst_pkg::HS_STB] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign prdata  = q.prdata;
    assign pready  = q.pready;
    assign pslverr = q.pslverr;
    assign y_out   = q.y_out;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_local_all_chan: assert property (
        (q.phase == S_DONE && !q.a_remote) |-> q.steps == q.a_in_cnt)
        else $error("local scan did not move every enabled input channel");
    a_remote_one_chan: assert property (
        (q.phase == S_DONE && q.a_remote) |-> q.steps == 4'h1)
        else $error("remote scan moved other than one input channel");
    a_rotate_order: assert property (
        (q.phase == S_DONE && q.a_remote && q.run) |=>
        rot_idx == ((4'($past(rot_idx)) + 4'h1 >= q.a_in_cnt) ? 3'h0 :
                    $past(rot_idx) + 3'h1))
        else $error("rotation did not advance to the next channel");
    a_local_out_all: assert property (
        (q.phase == S_DONE && !q.a_remote) |-> q.outs == q.a_out_cnt)
        else $error("local scan did not refresh every enabled output");
    a_remote_out_one: assert property (
        (q.phase == S_DONE && q.a_remote) |-> q.outs == 3'(q.k < q.a_out_cnt))
        else $error("remote scan refreshed the wrong number of outputs");
    a_out_sync_rot: assert property (
        q.y_out[amst_pkg::HS_STB] |->
        q.y_out[amst_pkg::HS_OUTCH +: 2] == q.y_out[amst_pkg::HS_INCH +: 2] &&
        q.y_out[amst_pkg::HS_INCH +: 3] < q.a_out_cnt)
        else $error("output refresh not aligned with input rotation");
    a_out_word_value: assert property (
        (q.phase == S_DRIVE && q.run) |=> q.y_out[15:0] == $past(q.out_val[q.k[1:0]]))
        else $error("first output word does not carry the channel value");
    a_handshake_own: assert property (
        q.y_out[31:amst_pkg::HS_TOP] == '0 &&
        (q.y_out[amst_pkg::HS_STB] -> q.y_out[amst_pkg::HS_SET +: 4] == q.a_set))
        else $error("handshake word holds foreign data");
    a_cfg_held: assert property (
        (q.run && q.run_d) |=> $stable(q.a_in_cnt) && $stable(q.a_remote) &&
        $stable(q.a_in_ptr) && $stable(q.a_out_cnt))
        else $error("scan settings changed without a mode transition");
    a_slot_addr: assert property (
        inp_addr - fmt_addr == amst_pkg::PTR_GAP && fmt_addr[2:0] == q.a_slot)
        else $error("slot configuration location is wrong");
    a_store_index: assert property (
        q.st_we |-> q.last_addr == q.a_in_ptr + 16'(q.st_idx) &&
        4'(q.st_idx) < q.a_in_cnt)
        else $error("input value stored at the wrong location");

    c_local_scan: cover property (q.phase == S_DONE && !q.a_remote && q.a_in_cnt == 4'h8);
    c_remote_scan: cover property (q.phase == S_DONE && q.a_remote);
    c_rotor_wrap: cover property (q.rot_step && rot_idx == 3'h7);
    c_id_mismatch: cover property ($rose(q.mism));
endmodule

// file: testbench/amst_amod_model.sv
// behavioural analog module answering the controller's scan points
module amst_amod_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [31:0] y_out,
    input  wire logic [15:0] base,
    input  wire logic        bad,
    output logic      [31:0] x_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] ch;
    assign ch = {13'h0, y_out[18:16]};
    // answers a cycle late, so the controller has to wait out its settle time
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            x_in <= 32'hffff_ffff;
        end else begin
            // bad flips the channel id to provoke a mismatch
            x_in <= {13'h0, y_out[18:16] ^ {2'b00, bad}, base + 16'h1111 * ch};
        end
    end
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the analog module scan controller
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] e;
        logic [31:0] m;
        logic        err;
    } amst_note_t;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, bad;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, x_in, y_out, q, prev;
    logic [15:0] base, ip, sl;
    logic [15:0] outv [4];
    logic [3:0]  setv;
    int          miscompares, total_checks;
    amst_note_t  cur;
    amst_note_t  notes [$];
    logic [31:0] evq [$];

    amst_host #(.SCAN_GAP_CYC(200)) uut (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .x_in(x_in), .y_out(y_out)
    );
    amst_amod_model model (.clk(clk), .rstn(rstn), .y_out(y_out), .base(base), .bad(bad),
                           .x_in(x_in));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic [31:0] m, input logic err);
        notes.push_back('{e & m, m, err});
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0, e, m, 1'b0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask

    task automatic wait_scans(input int t);
        do rd(amst_pkg::OFF_STAT, 32'h0, 32'h0); while (q[31:16] !== 16'(t));
    endtask

    // what one channel step shows on the output points
    function automatic logic [31:0] view(input logic [31:0] y);
        return {y[31:21], y[18:16], y[21] ? {y[20:19], y[15:0]} : 18'h0};
    endfunction

    function automatic logic [31:0] ev(input int k);
        logic s;
        s = (k < 4);
        return {6'h0, setv, s, 3'(k), s ? {2'(k), outv[k % 4]} : 18'h0};
    endfunction

    always @(posedge clk) begin
        if (rstn && psel && penable && pready === 1'b1) begin
            cur = notes.pop_front();
            check("prdata", prdata & cur.m, cur.e);
            check("pslverr", {31'h0, pslverr}, {31'h0, cur.err});
        end
    end

    // a step is a new channel asked for or a fresh output strobe
    always @(posedge clk) begin
        if (rstn && (y_out[18:16] !== prev[18:16] || (y_out[21] && !prev[21]))) begin
            check("step queued", {31'h0, evq.size() > 0}, 32'h1);
            if (evq.size() > 0) check("step", view(y_out), evq.pop_front());
        end
        prev <= y_out;
    end

    task automatic run_case(input logic r);
        logic [7:0] offs [5];
        offs = '{amst_pkg::OFF_CTRL, amst_pkg::OFF_SET, amst_pkg::OFF_PTR,
                 amst_pkg::OFF_STAT, amst_pkg::OFF_LAST};
        rstn <= 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        foreach (offs[i]) rd(offs[i], 32'h0, 32'hffff_ffff);
        apb(1'b0, 8'h50, 32'h0, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h50, 32'h1, 32'h0, 32'h0, 1'b1);
        sl = 16'($urandom % 8);
        setv = 4'($urandom);
        ip = 16'($urandom);
        base <= 16'($urandom);
        for (int k = 0; k < 4; k++) begin
            outv[k] = 16'($urandom);
            wr(8'(8'h40 + 4 * k), {16'h0, outv[k]});
            rd(8'(8'h40 + 4 * k), {16'h0, outv[k]}, 32'h0000_ffff);
        end
        wr(amst_pkg::OFF_SET, {28'h0, setv});
        wr(amst_pkg::OFF_PTR, {ip ^ 16'h5a5a, ip});
        for (int k = 0; k < 8; k++) evq.push_back(ev(k));
        wr(amst_pkg::OFF_CTRL, 32'h1 | (32'(r) << amst_pkg::CTRL_REMOTE)
           | (32'h8 << amst_pkg::CTRL_INCNT) | (32'h4 << amst_pkg::CTRL_OUTCNT)
           | (32'(sl) << amst_pkg::CTRL_SLOT));
        // read-only location words must ignore the write
        wr(amst_pkg::OFF_CFGA, 32'hffff_ffff);
        rd(amst_pkg::OFF_CFGA, {(r ? amst_pkg::EXP_INP : amst_pkg::LOC_INP) + sl,
           (r ? amst_pkg::EXP_FMT : amst_pkg::LOC_FMT) + sl}, 32'hffff_ffff);
        rd(amst_pkg::OFF_CFGB, {(r ? amst_pkg::EXP_RES : amst_pkg::LOC_RES) + sl,
           (r ? amst_pkg::EXP_OUTP : amst_pkg::LOC_OUTP) + sl}, 32'hffff_ffff);
        rd(amst_pkg::OFF_CFGC, {16'h0, (r ? amst_pkg::EXP_TH : amst_pkg::LOC_TH) + sl},
           32'hffff_ffff);
        // settings written while running wait for the next run rise
        wr(amst_pkg::OFF_SET, {28'h0, ~setv});
        for (int t = 1; t <= (r ? 8 : 1); t++) begin
            wait_scans(t);
            check("steps left", evq.size(), r ? 8 - t : 0);
            // the last remote scan answers with a wrong channel id
            bad <= (t == 7);
        end
        wr(amst_pkg::OFF_CTRL, 32'h0);
        rd(amst_pkg::OFF_STAT, {16'(r ? 8 : 1), 13'h0, r, r, 1'b0}, 32'hffff_0006);
        wr(amst_pkg::OFF_STAT, 32'h4);
        rd(amst_pkg::OFF_STAT, 32'h0, 32'h0000_0004);
        for (int k = 0; k < 8; k++) begin
            rd(8'(8'h20 + 4 * k), {16'h0, base + 16'h1111 * 16'(k)}, 32'hffff_ffff);
        end
        rd(amst_pkg::OFF_LAST, {16'h0, ip + 16'h7}, 32'hffff_ffff);
    endtask

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        rstn = 1'b0;
        bad = 1'b0;
        base = 16'h0;
        prev = 32'h0;
        miscompares = 0;
        total_checks = 0;
        q = $urandom(32'h48396704);
        run_case(1'b0);
        run_case(1'b1);
        report_and_stop();
    end

    // the two cases need well under ten thousand cycles
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
endmodule
